//--- verilog/cbs_cycle_sequencer.sv
// Per-instruction bus cycle sequencer: issues ordered bus cycles for one instruction form
`timescale 1ns/1ps
module cbs_cycle_sequencer
    import cbs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic        start_in,
    input  wire cbs_form_t   form_in,
    input  wire logic [31:0] opcode_addr_in,
    input  wire logic [31:0] operand_target_address_in,
    input  wire logic [31:0] vector_fetch_address_in,
    input  wire logic        cycle_done_in,
    output logic             busy_out,
    output logic             cyc_valid_out,
    output cbs_cycle_t       cyc_out,
    output logic             idle_state_out,
    output logic             bus_locked_out,
    output logic             done_out
);

    // Table of cycle lists, one step per entry; CYC_NONE ends the list
    function automatic cbs_step_t step_of(input cbs_form_t f, input logic [2:0] i);
        cbs_step_t s;
        s = '{CBS_CYC_NONE, CBS_SRC_NEXT, 1'b0};
        case (f)
            CBS_F_REG:
                if (i == 3'h0) s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b0};
            CBS_F_IMM16:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b0};
                    default: ;
                endcase
            CBS_F_IMM32:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RW, CBS_SRC_W3, 1'b0};
                    3'h2: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b0};
                    default: ;
                endcase
            CBS_F_BTST_IND:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RB, CBS_SRC_OPND, 1'b0};
                    3'h2: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b1};
                    default: ;
                endcase
            CBS_F_BTST_A16:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RW, CBS_SRC_W3, 1'b0};
                    3'h2: s = '{CBS_CYC_RB, CBS_SRC_OPND, 1'b0};
                    3'h3: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b1};
                    default: ;
                endcase
            CBS_F_BTST_A32:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RW, CBS_SRC_W3, 1'b0};
                    3'h2: s = '{CBS_CYC_RW, CBS_SRC_W4, 1'b0};
                    3'h3: s = '{CBS_CYC_RB, CBS_SRC_OPND, 1'b0};
                    3'h4: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b1};
                    default: ;
                endcase
            CBS_F_BR8:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b0};
                    3'h1: s = '{CBS_CYC_RW, CBS_SRC_OPND, 1'b0};
                    default: ;
                endcase
            CBS_F_BR16:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_IDLE, CBS_SRC_NEXT, 1'b0};
                    3'h2: s = '{CBS_CYC_RW, CBS_SRC_OPND, 1'b0};
                    default: ;
                endcase
            CBS_F_MCLR_IND:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RB, CBS_SRC_OPND, 1'b1};
                    3'h2: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b1};
                    3'h3: s = '{CBS_CYC_WB, CBS_SRC_OPND, 1'b0};
                    default: ;
                endcase
            CBS_F_MCLR_A16:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RW, CBS_SRC_W3, 1'b0};
                    3'h2: s = '{CBS_CYC_RB, CBS_SRC_OPND, 1'b1};
                    3'h3: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b1};
                    3'h4: s = '{CBS_CYC_WB, CBS_SRC_OPND, 1'b0};
                    default: ;
                endcase
            CBS_F_MCLR_A32:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RW, CBS_SRC_W3, 1'b0};
                    3'h2: s = '{CBS_CYC_RW, CBS_SRC_W4, 1'b0};
                    3'h3: s = '{CBS_CYC_RB, CBS_SRC_OPND, 1'b1};
                    3'h4: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b1};
                    3'h5: s = '{CBS_CYC_WB, CBS_SRC_OPND, 1'b0};
                    default: ;
                endcase
            CBS_F_EXT5:
                case (i)
                    3'h0: s = '{CBS_CYC_RW, CBS_SRC_W2, 1'b0};
                    3'h1: s = '{CBS_CYC_RW, CBS_SRC_W3, 1'b0};
                    3'h2: s = '{CBS_CYC_RW, CBS_SRC_W4, 1'b0};
                    3'h3: s = '{CBS_CYC_RW, CBS_SRC_W5, 1'b0};
                    3'h4: s = '{CBS_CYC_RW, CBS_SRC_NEXT, 1'b0};
                    default: ;
                endcase
            default: ;
        endcase
        return s;
    endfunction

    typedef enum logic [1:0]
    {
        CBS_ST_IDLE  = 2'b00,
        CBS_ST_ISSUE = 2'b01,
        CBS_ST_WAIT  = 2'b10
    } cbs_state_t;

    cbs_state_t  state;
    cbs_form_t   form;
    logic [2:0]  idx;
    logic [31:0] base;
    logic [31:0] opnd_addr;
    logic [31:0] vfa_addr;

    wire cbs_step_t   cur_step  = step_of(form, idx);
    wire cbs_step_t   nxt_step  = step_of(form, idx + 3'h1);
    wire logic        last_step = (nxt_step.kind == CBS_CYC_NONE);
    // Extension words sit at successive two-byte steps from the opcode
    wire logic [31:0] w2_addr   = base + CBS_WORD_STEP;
    wire logic [31:0] w3_addr   = w2_addr + CBS_WORD_STEP;
    wire logic [31:0] w4_addr   = w3_addr + CBS_WORD_STEP;
    wire logic [31:0] w5_addr   = w4_addr + CBS_WORD_STEP;
    // Next instruction follows the last extension word the form fetched
    wire logic [2:0]  ext_words = (form == CBS_F_REG || form == CBS_F_BR8) ? 3'h0 :
                                  (form == CBS_F_IMM32 || form == CBS_F_MCLR_A16 ||
                                   form == CBS_F_BTST_A16) ? 3'h2 :
                                  (form == CBS_F_BTST_A32 || form == CBS_F_MCLR_A32) ? 3'h3 :
                                  (form == CBS_F_EXT5) ? 3'h4 : 3'h1;
    wire logic [31:0] next_addr_calc = base + {28'h0, ext_words, 1'b0} + CBS_WORD_STEP;
    wire logic [31:0] sel_addr  = (cur_step.src == CBS_SRC_W2)  ? w2_addr :
                                  (cur_step.src == CBS_SRC_W3)  ? w3_addr :
                                  (cur_step.src == CBS_SRC_W4)  ? w4_addr :
                                  (cur_step.src == CBS_SRC_W5)  ? w5_addr :
                                  (cur_step.src == CBS_SRC_OPND) ? opnd_addr :
                                  (cur_step.src == CBS_SRC_VFA)  ? vfa_addr : next_addr_calc;
    wire logic        is_idle   = (cur_step.kind == CBS_CYC_IDLE);

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state          <= CBS_ST_IDLE;
            form           <= CBS_F_REG;
            idx            <= CBS_IDX_RESET;
            base           <= CBS_ADDR_RESET;
            opnd_addr      <= CBS_ADDR_RESET;
            vfa_addr       <= CBS_ADDR_RESET;
            busy_out       <= 1'b0;
            cyc_valid_out  <= 1'b0;
            cyc_out        <= '0;
            idle_state_out <= 1'b0;
            bus_locked_out <= 1'b0;
            done_out       <= 1'b0;
        end
        else
        begin
            done_out       <= 1'b0;
            idle_state_out <= 1'b0;
            case (state)
                CBS_ST_IDLE:
                    if (start_in)
                    begin
                        form      <= form_in;
                        base      <= opcode_addr_in;
                        opnd_addr <= operand_target_address_in;
                        vfa_addr  <= vector_fetch_address_in;
                        idx       <= CBS_IDX_RESET;
                        busy_out  <= 1'b1;
                        state     <= CBS_ST_ISSUE;
                    end
                CBS_ST_ISSUE:
                    if (is_idle)
                    begin
                        // One internal state, no bus access
                        idle_state_out <= 1'b1;
                        idx            <= idx + 3'h1;
                    end
                    else
                    begin
                        cyc_valid_out <= 1'b1;
                        cyc_out.addr  <= sel_addr;
                        cyc_out.write <= (cur_step.kind == CBS_CYC_WB) || (cur_step.kind == CBS_CYC_WW);
                        cyc_out.word  <= (cur_step.kind == CBS_CYC_RW) || (cur_step.kind == CBS_CYC_WW);
                        cyc_out.hold  <= cur_step.hold;
                        bus_locked_out <= 1'b1;
                        state         <= CBS_ST_WAIT;
                    end
                CBS_ST_WAIT:
                    if (cycle_done_in)
                    begin
                        cyc_valid_out <= 1'b0;
                        // Lock stays after a held cycle that is not the last step, so no grant slips in
                        bus_locked_out <= cyc_out.hold && !last_step;
                        if (last_step)
                        begin
                            busy_out <= 1'b0;
                            done_out <= 1'b1;
                            state    <= CBS_ST_IDLE;
                        end
                        else
                        begin
                            idx   <= idx + 3'h1;
                            state <= CBS_ST_ISSUE;
                        end
                    end
                default:
                    state <= CBS_ST_IDLE;
            endcase
        end
    end

endmodule

//--- verilog/cbs_pkg.sv
// Package for the bus cycle sequencer: cycle encodings, instruction forms, address sources
// Notes on behaviour
// - Each instruction form issues a fixed ordered list of byte/word read/write cycles.
// - Hold-marked cycle keeps bus ownership until the next cycle of the instruction.
// - 16-bit immediate fetches second word, then next; memory bit ops read a byte operand between.
// - 32-bit immediate ALU reads second, third words, then next: three word reads.
// - Bit test absolute 32: words 2-4, byte operand, then held next-instruction read.
// - Fetch addresses reach the fifth word, stepping by two bytes from opcode.
// - Every form but the 16-bit branch reads next instruction; 8-bit branches then read target either way.
// - 16-bit branch: second word, one idle internal state, then target read.
package cbs_pkg;

    typedef enum logic [2:0]
    {
        CBS_CYC_NONE = 3'h0,
        CBS_CYC_RB   = 3'h1,
        CBS_CYC_RW   = 3'h2,
        CBS_CYC_WB   = 3'h3,
        CBS_CYC_WW   = 3'h4,
        CBS_CYC_IDLE = 3'h5
    } cbs_kind_t;

    typedef enum logic [2:0]
    {
        CBS_SRC_W2   = 3'h0,
        CBS_SRC_W3   = 3'h1,
        CBS_SRC_W4   = 3'h2,
        CBS_SRC_W5   = 3'h3,
        CBS_SRC_NEXT = 3'h4,
        CBS_SRC_OPND = 3'h5,
        CBS_SRC_VFA  = 3'h6
    } cbs_src_t;

    typedef enum logic [3:0]
    {
        CBS_F_REG      = 4'h0,
        CBS_F_IMM16    = 4'h1,
        CBS_F_IMM32    = 4'h2,
        CBS_F_BTST_IND = 4'h3,
        CBS_F_BTST_A16 = 4'h4,
        CBS_F_BTST_A32 = 4'h5,
        CBS_F_BR8      = 4'h6,
        CBS_F_BR16     = 4'h7,
        CBS_F_MCLR_IND = 4'h8,
        CBS_F_MCLR_A16 = 4'h9,
        CBS_F_MCLR_A32 = 4'hA,
        CBS_F_EXT5     = 4'hB
    } cbs_form_t;

    typedef struct packed
    {
        cbs_kind_t kind;
        cbs_src_t  src;
        logic      hold;
    } cbs_step_t;

    typedef struct packed
    {
        logic [31:0] addr;
        logic        write;
        logic        word;
        logic        hold;
    } cbs_cycle_t;

    localparam int          CBS_MAX_STEPS   = 8;
    localparam logic [31:0] CBS_WORD_STEP   = 32'h0000_0002;
    localparam logic [2:0]  CBS_IDX_RESET   = 3'h0;
    localparam logic [31:0] CBS_ADDR_RESET  = 32'h0000_0000;

endpackage

//--- verif/cbs_mem_model.sv
// Memory and peripheral side: acknowledges each bus cycle after a chosen wait
`timescale 1ns/1ps
module cbs_mem_model
(
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       cyc_valid_in,
    input  wire logic [1:0] wait_in,
    output logic            cycle_done_out
);
    logic [1:0] cnt;

    // Never acknowledges twice in a row, so a dropped request is not answered again
    always_ff @(posedge clk_in)
    begin
        if (srst_in || !cyc_valid_in || cycle_done_out)
        begin
            cnt            <= 2'h0;
            cycle_done_out <= 1'b0;
        end
        else
        begin
            cnt            <= cnt + 2'h1;
            cycle_done_out <= (cnt == wait_in);
        end
    end
endmodule

//--- verif/cbs_cycle_sequencer_chk.sv
// Concurrent checks on the bus cycle sequencer ports
`timescale 1ns/1ps
module cbs_seq_chk
    import cbs_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       srst_in,
    input wire logic       start_in,
    input wire logic       cycle_done_in,
    input wire logic       busy_out,
    input wire logic       cyc_valid_out,
    input wire cbs_cycle_t cyc_out,
    input wire logic       idle_state_out,
    input wire logic       bus_locked_out,
    input wire logic       done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);

    a_start_first_cycle: assert property (start_in && !busy_out |=> busy_out ##[1:2] cyc_valid_out)
        else $error("first cycle late after start");
    a_request_held: assert property (cyc_valid_out && !cycle_done_in |=> cyc_valid_out && $stable(cyc_out))
        else $error("request changed before acknowledge");
    a_ack_releases: assert property (cyc_valid_out && cycle_done_in |=> !cyc_valid_out)
        else $error("request still up after acknowledge");
    a_lock_in_cycle: assert property (cyc_valid_out |-> bus_locked_out)
        else $error("bus not locked during a cycle");
    a_hold_keeps_lock: assert property (cyc_valid_out && cycle_done_in && cyc_out.hold
        |=> bus_locked_out[*2] or ##[0:1] done_out)
        else $error("bus released after a held cycle");
    a_done_single: assert property (done_out |=> !done_out)
        else $error("done wider than one cycle");
    a_done_quiet: assert property (done_out |-> !busy_out && !cyc_valid_out)
        else $error("done while still busy");
    a_idle_no_bus: assert property (idle_state_out |-> !cyc_valid_out ##1 !idle_state_out)
        else $error("idle state overlaps a bus cycle");
    a_write_byte: assert property (cyc_valid_out && cyc_out.write |-> !cyc_out.word && !cyc_out.hold)
        else $error("write cycle not an unheld byte");
endmodule

bind cbs_cycle_sequencer cbs_seq_chk u_cbs_seq_chk (.clk_in, .srst_in, .start_in, .cycle_done_in, .busy_out,
    .cyc_valid_out, .cyc_out, .idle_state_out, .bus_locked_out, .done_out);

//--- verif/testbench.sv
// Self-checking testbench for the bus cycle sequencer
`timescale 1ns/1ps
module testbench;
    import cbs_pkg::*;
    logic        clk_in;
    logic        srst_in;
    logic        start_in;
    cbs_form_t   form_in;
    logic [31:0] op;
    logic [31:0] opnd;
    logic [1:0]  slow;
    logic        cycle_done_in;
    logic        busy_out;
    logic        cyc_valid_out;
    cbs_cycle_t  cyc_out;
    logic        idle_state_out;
    logic        bus_locked_out;
    logic        done_out;
    cbs_cycle_t  got[$];
    cbs_cycle_t  want[$];
    int          n_mismatch;
    int          compares;
    // Idle marker: no real cycle is a held word write
    localparam cbs_cycle_t IDL = '1;

    cbs_cycle_sequencer u_cbs_cycle_sequencer (.clk_in, .srst_in, .start_in, .form_in, .opcode_addr_in(op),
        .operand_target_address_in(opnd), .vector_fetch_address_in(32'h0000_0100), .cycle_done_in, .busy_out,
        .cyc_valid_out, .cyc_out, .idle_state_out, .bus_locked_out, .done_out);
    cbs_mem_model u_cbs_mem_model (.clk_in, .srst_in, .cyc_valid_in(cyc_valid_out), .wait_in(slow),
        .cycle_done_out(cycle_done_in));

    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        if (cyc_valid_out === 1'b1 && cycle_done_in === 1'b1)
            got.push_back(cyc_out);
        if (idle_state_out === 1'b1)
            got.push_back(IDL);
    end

    function automatic cbs_cycle_t c(input logic [31:0] a, input logic w, input logic wd, input logic h);
        return '{a, w, wd, h};
    endfunction

    task automatic launch(input cbs_form_t f, input logic [31:0] a);
        got.delete();
        form_in  = f;
        op       = a;
        start_in = 1'b1;
        @(posedge clk_in);
        #1;
        start_in = 1'b0;
    endtask

    task automatic finish();
        int i;
        i = 0;
        while (done_out !== 1'b1 && i < 200)
        begin
            @(posedge clk_in);
            #1;
            i++;
        end
        compares++;
        if (i == 200 || got.size() != want.size())
        begin
            n_mismatch++;
            $display("mismatch at %0t: %0d cycles seen, %0d expected", $time, got.size(), want.size());
        end
        foreach (want[k])
        begin
            compares++;
            if (k >= got.size() || got[k] !== want[k])
            begin
                n_mismatch++;
                $display("mismatch at %0t: cycle %0d wrong", $time, k);
            end
        end
    endtask

    task automatic t_reg();
        launch(CBS_F_REG, 32'h0000_1000);
        want = '{c(32'h0000_1002, 0, 1, 0)};
        finish();
    endtask

    task automatic t_imm16();
        launch(CBS_F_IMM16, 32'h0000_1000);
        want = '{c(32'h0000_1002, 0, 1, 0), c(32'h0000_1004, 0, 1, 0)};
        finish();
    endtask

    task automatic t_imm32();
        launch(CBS_F_IMM32, 32'h0000_1000);
        want = '{c(32'h0000_1002, 0, 1, 0), c(32'h0000_1004, 0, 1, 0), c(32'h0000_1006, 0, 1, 0)};
        finish();
    endtask

    task automatic t_btst(input cbs_form_t f, input int ext);
        launch(f, 32'h0000_2000);
        want.delete();
        for (int k = 1; k <= ext; k++)
            want.push_back(c(32'h0000_2000 + 32'(2 * k), 0, 1, 0));
        want.push_back(c(opnd, 0, 0, 0));
        want.push_back(c(32'h0000_2000 + 32'(2 * ext + 2), 0, 1, 1));
        finish();
    endtask

    task automatic t_br8();
        launch(CBS_F_BR8, 32'h0000_3000);
        want = '{c(32'h0000_3002, 0, 1, 0), c(opnd, 0, 1, 0)};
        finish();
    endtask

    task automatic t_br16();
        launch(CBS_F_BR16, 32'h0000_3000);
        want = '{c(32'h0000_3002, 0, 1, 0), IDL, c(opnd, 0, 1, 0)};
        finish();
    endtask

    task automatic t_mclr(input cbs_form_t f, input int ext);
        launch(f, 32'h0000_5000);
        want.delete();
        for (int k = 1; k <= ext; k++)
            want.push_back(c(32'h0000_5000 + 32'(2 * k), 0, 1, 0));
        want.push_back(c(opnd, 0, 0, 1));
        want.push_back(c(32'h0000_5000 + 32'(2 * ext + 2), 0, 1, 1));
        want.push_back(c(opnd, 1, 0, 0));
        finish();
    endtask

    task automatic t_ext5();
        launch(CBS_F_EXT5, 32'hFFFF_FFF0);
        want = '{c(32'hFFFF_FFF2, 0, 1, 0), c(32'hFFFF_FFF4, 0, 1, 0), c(32'hFFFF_FFF6, 0, 1, 0),
                 c(32'hFFFF_FFF8, 0, 1, 0), c(32'hFFFF_FFFA, 0, 1, 0)};
        finish();
    endtask

    task automatic t_refuse();
        launch(CBS_F_IMM16, 32'h0000_1000);
        // A clock edge between lowering and raising start again
        @(posedge clk_in);
        #1;
        form_in  = CBS_F_REG;
        start_in = 1'b1;
        @(posedge clk_in);
        #1;
        start_in = 1'b0;
        want = '{c(32'h0000_1002, 0, 1, 0), c(32'h0000_1004, 0, 1, 0)};
        finish();
    endtask

    task automatic t_reset();
        launch(CBS_F_MCLR_A32, 32'h0000_4000);
        repeat (4) @(posedge clk_in);
        #1;
        srst_in = 1'b1;
        @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        compares++;
        if ({busy_out, cyc_valid_out, bus_locked_out, done_out} !== 4'h0)
        begin
            n_mismatch++;
            $display("mismatch at %0t: outputs not cleared by reset", $time);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        n_mismatch = 0;
        compares   = 0;
        srst_in    = 1'b1;
        start_in   = 1'b0;
        form_in    = CBS_F_REG;
        op         = 32'h0000_0000;
        opnd       = 32'h0000_8001;
        slow       = 2'h0;
        repeat (5) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        t_reg();
        t_imm16();
        t_imm32();
        t_btst(CBS_F_BTST_A32, 3);
        t_btst(CBS_F_BTST_IND, 1);
        t_btst(CBS_F_BTST_A16, 2);
        t_br8();
        t_br16();
        t_ext5();
        t_mclr(CBS_F_MCLR_IND, 1);
        slow = 2'h3;
        t_mclr(CBS_F_MCLR_A16, 2);
        t_refuse();
        t_reset();
        slow = 2'h1;
        t_mclr(CBS_F_MCLR_A32, 3);
        final_report();
    end

    initial
    begin
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule
